// >>> pkg/ist_pkg.sv
package ist_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_PORT_DIR    = 16'hff20;
    localparam logic [15:0] ADDR_PRESCALER   = 16'hffbb;
    localparam logic [15:0] ADDR_MODE_CTRL   = 16'hff60;
    localparam logic [15:0] ADDR_OUT_CTRL    = 16'hff61;
    localparam logic [15:0] ADDR_CMP_A_LO    = 16'hff62;
    localparam logic [15:0] ADDR_CMP_A_HI    = 16'hff63;
    localparam logic [15:0] ADDR_CMP_B_LO    = 16'hff64;
    localparam logic [15:0] ADDR_CMP_B_HI    = 16'hff65;
    localparam logic [15:0] ADDR_COUNT_LO    = 16'hff66;
    localparam logic [15:0] ADDR_COUNT_HI    = 16'hff67;
    localparam logic [15:0] ADDR_IRQ_STATUS  = 16'hff68;
    // reset values
    localparam logic [7:0]  RST_PORT_DIR     = 8'hff;
    localparam logic [7:0]  RST_PRESCALER    = 8'h00;
    localparam logic [7:0]  RST_MODE_CTRL    = 8'h00;
    localparam logic [7:0]  RST_OUT_CTRL     = 8'h00;
    localparam logic [15:0] RST_CMP          = 16'h0000;
    // prescaler field positions and masks
    localparam int          POS_EDGE_B       = 6;
    localparam int          POS_EDGE_A       = 4;
    localparam int          POS_CLK_SEL      = 0;
    localparam logic [7:0]  PRESCALER_MASK   = 8'hf3;
    // port direction: upper bits fixed to one
    localparam logic [7:0]  PORT_DIR_FIXED   = 8'hfc;
    // mode control: run mode bits 3:2
    localparam int          POS_RUN_MODE     = 2;
    localparam logic [7:0]  MODE_CTRL_MASK   = 8'h0c;
    // output control bits
    localparam int          POS_OUT_ENABLE   = 0;
    localparam int          POS_TOGGLE_A     = 1;
    localparam int          POS_TOGGLE_B     = 4;
    localparam logic [7:0]  OUT_CTRL_MASK    = 8'h13;
    // edge codes
    localparam logic [1:0]  EDGE_FALL        = 2'h0;
    localparam logic [1:0]  EDGE_RISE        = 2'h1;
    localparam logic [1:0]  EDGE_BOTH        = 2'h3;
    // count clock codes
    localparam logic [1:0]  CLK_FULL         = 2'h0;
    localparam logic [1:0]  CLK_DIV4         = 2'h1;
    localparam logic [1:0]  CLK_EDGE_A       = 2'h3;
    localparam logic [1:0]  DIV4_LAST        = 2'h3;
    // run modes
    typedef enum logic [1:0] {
        IST_STOP        = 2'b00,
        IST_FREE        = 2'b01,
        IST_CLR_EDGE    = 2'b10,
        IST_CLR_MATCH   = 2'b11
    } ist_run_e;
endpackage

// >>> src/ist_timer.sv
`timescale 1ns/1ps
// Behaviour
// [R1] prescaler rewrite only while stopped
// [R2] prescaler resets to zero
// [R3] edge b field selects fall/rise/both
// [R4] edge a field selects fall/rise/both
// [R5] clock field: full, div4, edge a
// [R6] edge a clock excludes edge clear, capture
// [R7] first enable treats high as rising
// [R8] external pulses two cycles longer
// [R9] direction bits, upper six read one
// [R10] software sets direction and latch
// [R11] shared pin: one function at once
// [R12] match-clear mode counts up on clock
// [R13] match a clears counter, raises irq
// [R14] interval is compare plus one
// [R15] compare a never programmed zero
// [R16] compare b match always raises irq
// [R17] output control 03 toggles on match
// [R18] square wave period twice interval
// [R19] run mode 00 stops, clears counter
// [R20] configure before starting match-clear mode
// [R21] toggle bit gates inversion, irq always
// [R22] output enable off forces pin low
// [R23] edge accepted after two equal samples
// [R24] prescaler bits 3:2 read zero
// [R25] div4 is one-cycle enable pulse
module ist_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [15:0]       addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [7:0]        rdata,
    input  wire logic              edge_input_a,
    input  wire logic              edge_input_b,
    output logic                   timer_out_pin,
    output logic                   dir_bit_input_a,
    output logic                   dir_bit_shared_pin,
    output logic                   match_irq_a,
    output logic                   match_irq_b,
    output logic                   edge_irq_b
);

    typedef struct packed {
        logic [7:0]       port_pin_direction;
        logic [7:0]       prescaler_edge_select;
        logic [7:0]       timer_mode_ctrl;
        logic [7:0]       output_ctrl_reg;
        logic [CNT_W-1:0] compare_reg_a;
        logic [CNT_W-1:0] compare_reg_b;
        logic [CNT_W-1:0] up_counter;
        logic [1:0]       div4_cnt;
        logic [1:0]       sync_a;
        logic [1:0]       sync_b;
        logic [1:0]       hist_a;
        logic [1:0]       hist_b;
        logic             level_a;
        logic             level_b;
        logic             armed;
        logic             started_once;
        logic             out_level;
        logic             irq_a;
        logic             irq_b;
        logic             irq_edge_b;
        logic [1:0]       sticky;
        logic [7:0]       rdata;
    } ist_state_s;

    ist_state_s cur;
    ist_state_s nxt;

    // true when an accepted level change matches the selected edge code
    function automatic logic edge_hit(input logic [1:0] sel, input logic old_lvl,
                                      input logic new_lvl);
        logic hit;
        hit = 1'b0;
        case (sel)
            ist_pkg::EDGE_FALL: begin
                hit = old_lvl & ~new_lvl; // [R3] [R4]
            end
            ist_pkg::EDGE_RISE: begin
                hit = ~old_lvl & new_lvl; // [R3] [R4]
            end
            ist_pkg::EDGE_BOTH: begin
                hit = old_lvl ^ new_lvl; // [R3] [R4]
            end
            default: begin
                hit = 1'b0; // prohibited code: no edge
            end
        endcase
        return hit;
    endfunction

    // a level change counts only after two consecutive samples agree
    function automatic logic filter_level(input logic [1:0] hist, input logic held);
        logic lvl;
        lvl = held;
        if (hist[0] == hist[1]) begin
            lvl = hist[0];
        end
        return lvl;
    endfunction

    // byte lanes of a count-wide register; lanes above the width are dropped
    function automatic logic [CNT_W-1:0] put_byte(input logic [CNT_W-1:0] old_val,
                                                  input logic hi, input logic [7:0] byte_val);
        logic [CNT_W+7:0] wide;
        wide = {8'h00, old_val};
        if (hi) begin
            wide[15:8] = byte_val;
        end else begin
            wide[7:0] = byte_val;
        end
        return wide[CNT_W-1:0];
    endfunction

    // lanes above the width read as zero
    function automatic logic [7:0] get_byte(input logic [CNT_W-1:0] val, input logic hi);
        logic [CNT_W+7:0] wide;
        wide = {8'h00, val};
        return hi ? wide[15:8] : wide[7:0];
    endfunction

    ist_pkg::ist_run_e run_mode;
    logic [1:0]        edge_a_sel;
    logic [1:0]        edge_b_sel;
    logic [1:0]        clk_sel;
    logic              valid_a;
    logic              valid_b;
    logic              filt_a;
    logic              filt_b;
    logic              count_tick;
    logic              match_a;
    logic              match_b;
    logic [CNT_W-1:0]  cnt_inc;

    always_comb begin
        nxt = cur;
        run_mode   = ist_pkg::ist_run_e'(cur.timer_mode_ctrl[ist_pkg::POS_RUN_MODE +: 2]);
        edge_b_sel = cur.prescaler_edge_select[ist_pkg::POS_EDGE_B +: 2];
        edge_a_sel = cur.prescaler_edge_select[ist_pkg::POS_EDGE_A +: 2];
        clk_sel    = cur.prescaler_edge_select[ist_pkg::POS_CLK_SEL +: 2];
        nxt.irq_a      = 1'b0;
        nxt.irq_b      = 1'b0;
        nxt.irq_edge_b = 1'b0;
        nxt.rdata      = 8'h00;

        // two-flop synchronisers; filter looks only at the second stage onward
        nxt.sync_a = {cur.sync_a[0], edge_input_a};
        nxt.sync_b = {cur.sync_b[0], edge_input_b};
        nxt.hist_a = {cur.hist_a[0], cur.sync_a[1]};
        nxt.hist_b = {cur.hist_b[0], cur.sync_b[1]};

        // level accepted only when two consecutive samples agree
        filt_a = filter_level(cur.hist_a, cur.level_a); // [R23]
        filt_b = filter_level(cur.hist_b, cur.level_b); // [R23]
        nxt.level_a = filt_a;
        nxt.level_b = filt_b;

        // first enable after reset: old level taken as low so a high reads as rising
        if (cur.armed) begin
            valid_a = edge_hit(edge_a_sel, cur.level_a, filt_a);
            valid_b = edge_hit(edge_b_sel, cur.level_b, filt_b);
        end else begin
            valid_a = edge_hit(edge_a_sel, cur.started_once ? filt_a : 1'b0, filt_a); // [R7]
            valid_b = edge_hit(edge_b_sel, cur.started_once ? filt_b : 1'b0, filt_b); // [R7]
        end
        if (run_mode == ist_pkg::IST_STOP) begin
            valid_a = 1'b0;
            valid_b = 1'b0;
        end
        nxt.armed = (run_mode != ist_pkg::IST_STOP);
        if (cur.armed) begin
            nxt.started_once = 1'b1;
        end

        // divider keeps everything on mclk as a one-cycle enable
        if (run_mode == ist_pkg::IST_STOP) begin
            nxt.div4_cnt = 2'h0;
        end else begin
            nxt.div4_cnt = cur.div4_cnt + 2'h1; // [R25]
        end
        case (clk_sel)
            ist_pkg::CLK_FULL: begin
                count_tick = 1'b1; // [R5]
            end
            ist_pkg::CLK_DIV4: begin
                count_tick = (cur.div4_cnt == ist_pkg::DIV4_LAST); // [R5] [R25]
            end
            ist_pkg::CLK_EDGE_A: begin
                count_tick = valid_a; // [R5] [R6]
            end
            default: begin
                count_tick = 1'b0;
            end
        endcase

        match_a = (cur.up_counter == cur.compare_reg_a);
        match_b = (cur.up_counter == cur.compare_reg_b);
        cnt_inc = cur.up_counter + {{(CNT_W-1){1'b0}}, 1'b1};

        if (run_mode == ist_pkg::IST_STOP) begin
            nxt.up_counter = '0; // [R19]
        end else if (count_tick) begin
            // compare a of zero would fire every tick; software keeps it nonzero
            if (run_mode == ist_pkg::IST_CLR_MATCH && match_a) begin
                nxt.up_counter = '0; // [R13] [R14] [R15]
            end else if (run_mode == ist_pkg::IST_CLR_EDGE && valid_a) begin
                nxt.up_counter = '0;
            end else begin
                nxt.up_counter = cnt_inc; // [R12]
            end
            if (match_a) begin
                nxt.irq_a = 1'b1; // [R13] [R21]
                if (cur.output_ctrl_reg[ist_pkg::POS_TOGGLE_A]) begin
                    nxt.out_level = ~cur.out_level; // [R17] [R18] [R21]
                end
            end
            if (match_b) begin
                nxt.irq_b = 1'b1; // [R16]
                if (cur.output_ctrl_reg[ist_pkg::POS_TOGGLE_B]) begin
                    nxt.out_level = ~nxt.out_level;
                end
            end
        end
        if (valid_b) begin
            nxt.irq_edge_b = 1'b1;
        end
        if (!cur.output_ctrl_reg[ist_pkg::POS_OUT_ENABLE]) begin
            nxt.out_level = 1'b0; // [R22]
        end

        // sticky view of match events; set beats a read-clear in the same cycle
        if (rd_en && addr == ist_pkg::ADDR_IRQ_STATUS) begin
            nxt.sticky = 2'b00;
        end
        nxt.sticky = nxt.sticky | {nxt.irq_b, nxt.irq_a};

        if (wr_en) begin
            case (addr)
                ist_pkg::ADDR_PORT_DIR: begin
                    nxt.port_pin_direction = wdata | ist_pkg::PORT_DIR_FIXED; // [R9] [R10]
                end
                ist_pkg::ADDR_PRESCALER: begin
                    // writes during a run are blocked rather than corrupting the count
                    if (run_mode == ist_pkg::IST_STOP) begin
                        nxt.prescaler_edge_select = wdata & ist_pkg::PRESCALER_MASK; // [R1] [R24]
                    end
                end
                ist_pkg::ADDR_MODE_CTRL: begin
                    nxt.timer_mode_ctrl = wdata & ist_pkg::MODE_CTRL_MASK; // [R20]
                end
                ist_pkg::ADDR_OUT_CTRL: begin
                    nxt.output_ctrl_reg = wdata & ist_pkg::OUT_CTRL_MASK;
                end
                // halves land independently; software owns the pair ordering
                ist_pkg::ADDR_CMP_A_LO: begin
                    nxt.compare_reg_a = put_byte(cur.compare_reg_a, 1'b0, wdata);
                end
                ist_pkg::ADDR_CMP_A_HI: begin
                    nxt.compare_reg_a = put_byte(cur.compare_reg_a, 1'b1, wdata);
                end
                ist_pkg::ADDR_CMP_B_LO: begin
                    nxt.compare_reg_b = put_byte(cur.compare_reg_b, 1'b0, wdata);
                end
                ist_pkg::ADDR_CMP_B_HI: begin
                    nxt.compare_reg_b = put_byte(cur.compare_reg_b, 1'b1, wdata);
                end
                default: begin
                end
            endcase
        end

        if (rd_en) begin
            case (addr)
                ist_pkg::ADDR_PORT_DIR: begin
                    nxt.rdata = cur.port_pin_direction;
                end
                ist_pkg::ADDR_PRESCALER: begin
                    nxt.rdata = cur.prescaler_edge_select; // [R24]
                end
                ist_pkg::ADDR_MODE_CTRL: begin
                    nxt.rdata = cur.timer_mode_ctrl;
                end
                ist_pkg::ADDR_OUT_CTRL: begin
                    nxt.rdata = cur.output_ctrl_reg;
                end
                ist_pkg::ADDR_CMP_A_LO: begin
                    nxt.rdata = get_byte(cur.compare_reg_a, 1'b0);
                end
                ist_pkg::ADDR_CMP_A_HI: begin
                    nxt.rdata = get_byte(cur.compare_reg_a, 1'b1);
                end
                ist_pkg::ADDR_CMP_B_LO: begin
                    nxt.rdata = get_byte(cur.compare_reg_b, 1'b0);
                end
                ist_pkg::ADDR_CMP_B_HI: begin
                    nxt.rdata = get_byte(cur.compare_reg_b, 1'b1);
                end
                // count bytes are read live, so a two-byte read is not atomic
                ist_pkg::ADDR_COUNT_LO: begin
                    nxt.rdata = get_byte(cur.up_counter, 1'b0);
                end
                ist_pkg::ADDR_COUNT_HI: begin
                    nxt.rdata = get_byte(cur.up_counter, 1'b1);
                end
                ist_pkg::ADDR_IRQ_STATUS: begin
                    nxt.rdata = {6'h00, cur.sticky};
                end
                default: begin
                    nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur                       <= '0;
            cur.port_pin_direction    <= ist_pkg::RST_PORT_DIR; // [R9]
            cur.prescaler_edge_select <= ist_pkg::RST_PRESCALER; // [R2]
            cur.timer_mode_ctrl       <= ist_pkg::RST_MODE_CTRL;
            cur.output_ctrl_reg       <= ist_pkg::RST_OUT_CTRL;
            cur.compare_reg_a         <= ist_pkg::RST_CMP;
            cur.compare_reg_b         <= ist_pkg::RST_CMP;
        end else begin
            cur <= nxt;
        end
    end

    // pin drives only when the shared pin is in output mode [R11]
    assign timer_out_pin      = cur.out_level & ~cur.port_pin_direction[1];
    assign dir_bit_input_a    = cur.port_pin_direction[0];
    assign dir_bit_shared_pin = cur.port_pin_direction[1];
    assign match_irq_a        = cur.irq_a;
    assign match_irq_b        = cur.irq_b;
    assign edge_irq_b         = cur.irq_edge_b;
    assign rdata              = cur.rdata;

endmodule // ist_timer

// >>> dv/ist_timer_asserts.sv
`timescale 1ns/1ps
module ist_timer_asserts (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  rdata,
    input wire logic        edge_input_a,
    input wire logic        edge_input_b,
    input wire logic        timer_out_pin,
    input wire logic        dir_bit_input_a,
    input wire logic        dir_bit_shared_pin,
    input wire logic        match_irq_a,
    input wire logic        match_irq_b,
    input wire logic        edge_irq_b
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_rst_vals;
        $fell(rst) |-> dir_bit_input_a && dir_bit_shared_pin && !timer_out_pin;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("pin state wrong after reset");
    property p_dir_rd;
        rd_en && addr == ist_pkg::ADDR_PORT_DIR |=>
            rdata == {6'h3f, dir_bit_shared_pin, dir_bit_input_a};
    endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("direction read wrong");
    property p_pre_rd;
        rd_en && addr == ist_pkg::ADDR_PRESCALER |=> rdata[3:2] == 2'h0;
    endproperty
    a_pre_rd: assert property (p_pre_rd) else $error("fixed prescaler bits not zero");
    property p_out_in;
        dir_bit_shared_pin |-> !timer_out_pin;
    endproperty
    a_out_in: assert property (p_out_in) else $error("output driven on input pin");
    // a rising output is only a match toggle; a direction change may also expose it
    property p_out_rise;
        $rose(timer_out_pin) && $stable(dir_bit_shared_pin) |-> match_irq_a;
    endproperty
    a_out_rise: assert property (p_out_rise) else $error("output rose without match");
    property p_irq_a;
        match_irq_a |=> !match_irq_a;
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("match a pulse too long");
    property p_irq_b;
        match_irq_b |=> !match_irq_b;
    endproperty
    a_irq_b: assert property (p_irq_b) else $error("match b pulse too long");
    property p_edge_b;
        edge_irq_b |=> !edge_irq_b;
    endproperty
    a_edge_b: assert property (p_edge_b) else $error("edge b pulses adjacent");
    cover property (match_irq_a && timer_out_pin);
    cover property (match_irq_b);
    cover property (edge_irq_b);
endmodule // ist_timer_asserts

// >>> dv/ist_pulse_src.sv
`timescale 1ns/1ps
module ist_pulse_src #(
    parameter int HALF = 6
) (
    input  wire logic mclk,
    input  wire logic run,
    output logic      edge_input_a,
    output logic      edge_input_b
);
    int cnt = 0;
    initial begin
        edge_input_a = 1'b0;
        edge_input_b = 1'b0;
    end
    // levels held HALF cycles, well past the two-sample filter; still when not running
    always @(posedge mclk) begin
        cnt <= run ? (cnt + 1) % HALF : 0;
        if (run && cnt == HALF - 1) begin
            edge_input_a <= !edge_input_a;
            edge_input_b <= !edge_input_b;
        end
    end
endmodule // ist_pulse_src

// >>> dv/ist_timer_tb.sv
`timescale 1ns/1ps
module ist_timer_tb;
    localparam int HALF = 6;
    logic        mclk, rst, wr_en, rd_en, run, o;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata;
    logic        edge_input_a, edge_input_b, timer_out_pin, dir_bit_input_a;
    logic        dir_bit_shared_pin, match_irq_a, match_irq_b, edge_irq_b;
    logic [1:0]  codes [3] = '{ist_pkg::EDGE_FALL, ist_pkg::EDGE_RISE, ist_pkg::EDGE_BOTH};
    int          errors = 0, check_count = 0, n, nb, nt, mb;
    ist_timer ist_timer_inst (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .edge_input_a(edge_input_a),
        .edge_input_b(edge_input_b), .timer_out_pin(timer_out_pin),
        .dir_bit_input_a(dir_bit_input_a), .dir_bit_shared_pin(dir_bit_shared_pin),
        .match_irq_a(match_irq_a), .match_irq_b(match_irq_b), .edge_irq_b(edge_irq_b));
    ist_pulse_src #(.HALF(HALF)) ist_pulse_src_inst (.mclk(mclk), .run(run),
        .edge_input_a(edge_input_a), .edge_input_b(edge_input_b));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        chk(rdata, e);
    endtask
    // one full match-to-match interval; counts cycles, b edges, b matches, output flips
    task meas;
        int k;
        k = 0;
        n = 0; nb = 0; nt = 0; mb = 0;
        do begin @(negedge mclk); k++; end while (match_irq_a !== 1'b1 && k < 3000);
        o = timer_out_pin;
        do begin
            @(negedge mclk);
            n++;
            nb += (edge_irq_b === 1'b1);
            mb += (match_irq_b === 1'b1);
            nt += (timer_out_pin !== o);
            o = timer_out_pin;
        end while (match_irq_a !== 1'b1 && n < 3000);
    endtask
    task test_done;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #3000000;
        errors++;
        test_done();
    end
    initial begin
        rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; addr = 16'h0000; wdata = 8'h00; run = 1'b0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd(ist_pkg::ADDR_PORT_DIR, 8'hff);
        rd(ist_pkg::ADDR_PRESCALER, 8'h00);
        rd(16'hff00, 8'h00);
        wr(ist_pkg::ADDR_PORT_DIR, 8'h00);
        rd(ist_pkg::ADDR_PORT_DIR, 8'hfc);
        chk(dir_bit_shared_pin, 1'b0);
        wr(ist_pkg::ADDR_PRESCALER, 8'hff);
        rd(ist_pkg::ADDR_PRESCALER, 8'hf3);
        wr(ist_pkg::ADDR_CMP_A_LO, 8'h03);
        wr(ist_pkg::ADDR_CMP_A_HI, 8'h00);
        wr(ist_pkg::ADDR_CMP_B_LO, 8'h01);
        wr(ist_pkg::ADDR_CMP_B_HI, 8'h00);
        for (int c = 0; c < 2; c++) begin
            wr(ist_pkg::ADDR_OUT_CTRL, 8'h03);
            wr(ist_pkg::ADDR_PRESCALER, c[7:0]);
            wr(ist_pkg::ADDR_MODE_CTRL, 8'h0c);
            wr(ist_pkg::ADDR_PRESCALER, 8'h03);
            rd(ist_pkg::ADDR_PRESCALER, c[7:0]);
            meas();
            chk(n, c ? 16 : 4);
            chk(nt, 1);
            chk(mb, 1);
            wr(ist_pkg::ADDR_MODE_CTRL, 8'h00);
            rd(ist_pkg::ADDR_COUNT_LO, 8'h00);
        end
        // toggle off must still interrupt; output-enable off must hold the pin low
        for (int v = 1; v < 3; v++) begin
            wr(ist_pkg::ADDR_OUT_CTRL, v[7:0]);
            wr(ist_pkg::ADDR_MODE_CTRL, 8'h0c);
            meas();
            chk(n, 16);
            chk(nt, 0);
            if (v == 2) chk(timer_out_pin, 1'b0);
            wr(ist_pkg::ADDR_MODE_CTRL, 8'h00);
        end
        // counting edges of input a, with b on the shared pin as an input
        wr(ist_pkg::ADDR_PORT_DIR, 8'h03);
        wr(ist_pkg::ADDR_OUT_CTRL, 8'h00);
        foreach (codes[i]) begin
            wr(ist_pkg::ADDR_PRESCALER, {codes[i], codes[i], 4'h3});
            run <= 1'b1;
            wr(ist_pkg::ADDR_MODE_CTRL, 8'h0c);
            meas();
            chk(n, (codes[i] == ist_pkg::EDGE_BOTH ? 1 : 2) * HALF * 4);
            chk(nb, 4);
            wr(ist_pkg::ADDR_MODE_CTRL, 8'h00);
            run <= 1'b0;
        end
        // reset in a run; first enable must see a high pin a as a rising edge
        wr(ist_pkg::ADDR_MODE_CTRL, 8'h0c);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(ist_pkg::ADDR_PRESCALER, 8'h00);
        run <= 1'b1;
        wait (edge_input_a === 1'b1);
        @(posedge mclk);
        run <= 1'b0;
        wr(ist_pkg::ADDR_PRESCALER, {ist_pkg::EDGE_FALL, ist_pkg::EDGE_RISE, 4'h3});
        wr(ist_pkg::ADDR_CMP_A_LO, 8'h03);
        wr(ist_pkg::ADDR_MODE_CTRL, 8'h0c);
        rd(ist_pkg::ADDR_COUNT_LO, 8'h01);
        rd(ist_pkg::ADDR_COUNT_HI, 8'h00);
        rd(ist_pkg::ADDR_IRQ_STATUS, 8'h02);
        rd(ist_pkg::ADDR_IRQ_STATUS, 8'h00);
        wr(ist_pkg::ADDR_MODE_CTRL, 8'h00);
        wr(ist_pkg::ADDR_MODE_CTRL, 8'h0c);
        rd(ist_pkg::ADDR_COUNT_LO, 8'h00);
        test_done();
    end
endmodule // ist_timer_tb
bind ist_timer ist_timer_asserts ist_timer_asserts_inst (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .edge_input_a(edge_input_a),
    .edge_input_b(edge_input_b), .timer_out_pin(timer_out_pin),
    .dir_bit_input_a(dir_bit_input_a), .dir_bit_shared_pin(dir_bit_shared_pin),
    .match_irq_a(match_irq_a), .match_irq_b(match_irq_b), .edge_irq_b(edge_irq_b));
